//--- adc_acc_pkg.sv
package adc_acc_pkg;

	// widths of the sample, the accumulator and the select fields
	localparam int SAMPLE_W = 10;
	localparam int ACC_W    = 16;
	localparam int SEL_W    = 3;
	localparam int CNT_W    = 7;
	localparam int PAD_W    = ACC_W - SAMPLE_W;

	// repeat count select encodings
	localparam logic [SEL_W-1:0] RPT_1  = 3'h0;
	localparam logic [SEL_W-1:0] RPT_4  = 3'h1;
	localparam logic [SEL_W-1:0] RPT_8  = 3'h2;
	localparam logic [SEL_W-1:0] RPT_16 = 3'h3;
	localparam logic [SEL_W-1:0] RPT_32 = 3'h4;

	// justify / shift select encodings
	localparam logic [SEL_W-1:0] JUST_RIGHT = 3'h0;
	localparam logic [SEL_W-1:0] JUST_SHR1  = 3'h1;
	localparam logic [SEL_W-1:0] JUST_SHR2  = 3'h2;
	localparam logic [SEL_W-1:0] JUST_SHR3  = 3'h3;
	localparam logic [SEL_W-1:0] JUST_LEFT  = 3'h4;

	// reset values
	localparam logic [ACC_W-1:0] RESULT_RST = 16'h0000;
	localparam logic [ACC_W-1:0] ACC_RST    = 16'h0000;

	// burst power-up wait
	localparam int CLK_PERIOD_NS = 10;
	localparam int PWRUP_TIME_NS = 2000;
	localparam int PWRUP_CYCLES  = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PWR_W         = $clog2(PWRUP_CYCLES + 1);

	typedef struct packed {
		logic                 burst_mode_enable;
		logic [SEL_W-1:0]     repeat_count_select;
		logic [SEL_W-1:0]     justify_shift_select;
	} acc_cfg_t;

	typedef struct packed {
		logic [7:0] result_high_byte;
		logic [7:0] result_low_byte;
	} result_t;

	// number of samples in one series; codes above 32 all mean 64
	function automatic logic [CNT_W-1:0] repeat_len(input logic [SEL_W-1:0] sel);
		case (sel)
			RPT_1:   repeat_len = 7'h01;
			RPT_4:   repeat_len = 7'h04;
			RPT_8:   repeat_len = 7'h08;
			RPT_16:  repeat_len = 7'h10;
			RPT_32:  repeat_len = 7'h20;
			default: repeat_len = 7'h40;
		endcase
	endfunction

endpackage

//--- result_formatter.sv
`timescale 1ns/1ns
module result_formatter
	import adc_acc_pkg::*;
(
	input  wire logic [ACC_W-1:0] total_i,
	input  wire logic [SEL_W-1:0] justify_shift_select_i,
	output logic      [ACC_W-1:0] word_o
);

	// right justify, shift right, or left justify the running total
	always_comb begin
		case (justify_shift_select_i)
			JUST_RIGHT: word_o = total_i;
			JUST_SHR1:  word_o = total_i >> 1;
			JUST_SHR2:  word_o = total_i >> 2;
			JUST_SHR3:  word_o = total_i >> 3;
			// any 1xx code left justifies; low pad bits read zero
			default:    word_o = {total_i[SAMPLE_W-1:0], {PAD_W{1'b0}}};
		endcase
	end

endmodule

//--- adc_result_accumulator.sv
`timescale 1ns/1ns
// Summary of operation
// - with repeat count one, each result is a plain 10-bit unsigned code.
// - select 000 gives right justified, 100 gives left justified at bit 15.
// - result bytes load when a conversion or a whole series completes.
// - series of 4, 8, 16, 32 or 64 samples are summed unsigned.
// - for counts above one, result bytes change only after the last sample.
// - 16-bit accumulator; select may shift the total right by 1, 2 or 3.
// - burst mode powers converter up, runs the series, then powers it down.
// - done flag sets only after the full repeat count has been summed.
// - result bytes hold valid data whenever the done flag is set.
// - in burst mode one start runs as many conversions as the repeat count.
module adc_result_accumulator
	import adc_acc_pkg::*;
#(
	parameter int PWRUP_WAIT = PWRUP_CYCLES
)(
	input  wire logic                sys_clk_i,
	input  wire logic                sys_rst_i,
	input  wire acc_cfg_t            cfg_i,
	input  wire logic                convert_start_i,
	input  wire logic                done_clear_i,
	input  wire logic                sample_valid_i,
	input  wire logic [SAMPLE_W-1:0] sample_data_i,
	output result_t                  result_o,
	output logic                     conversion_done_flag_o,
	output logic                     busy_o,
	output logic                     converter_enable_o,
	output logic                     converter_start_o
);

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_POWERUP = 2'b01,
		ST_CONVERT = 2'b10
	} seq_state_t;

	localparam logic [PWR_W-1:0] PWR_LAST = PWR_W'(PWRUP_WAIT - 1);
	// follows the instance's own wait, not the package default
	localparam int               PWR_BOUND = PWRUP_WAIT + 1;

	seq_state_t          state;
	logic [PWR_W-1:0]    pwr_count;
	logic [CNT_W-1:0]    sample_count;
	logic [ACC_W-1:0]    acc;
	logic [ACC_W-1:0]    next_total;
	logic [ACC_W-1:0]    formatted;
	logic [CNT_W-1:0]    series_len;
	logic                series_last;

	// running sum; first sample of a series replaces the old total
	assign series_len  = repeat_len(cfg_i.repeat_count_select);
	assign series_last = sample_valid_i && (sample_count == series_len - 7'h01);
	assign next_total  = (sample_count == 7'h00)
		? {{PAD_W{1'b0}}, sample_data_i}
		: acc + {{PAD_W{1'b0}}, sample_data_i};

	result_formatter u_formatter (
		.total_i                (next_total),
		.justify_shift_select_i (cfg_i.justify_shift_select),
		.word_o                 (formatted)
	);

	// accumulator and sample counter; 64 full-scale codes still fit 16 bits
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			acc          <= ACC_RST;
			sample_count <= 7'h00;
		end else if (sample_valid_i) begin
			acc <= next_total;
			if (series_last)
				sample_count <= 7'h00;
			else
				sample_count <= sample_count + 7'h01;
		end
	end

	// result bytes move only on the closing sample of a series
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			result_o <= RESULT_RST;
		end else if (series_last) begin
			result_o <= formatted;
		end
	end

	// done flag; a completing series beats a same-cycle clear
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i)
			conversion_done_flag_o <= 1'b0;
		else if (series_last)
			conversion_done_flag_o <= 1'b1;
		else if (done_clear_i)
			conversion_done_flag_o <= 1'b0;
	end

	// sequencer: normal mode one conversion per start, burst runs a series
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			state             <= ST_IDLE;
			pwr_count         <= '0;
			converter_start_o <= 1'b0;
			busy_o            <= 1'b0;
		end else begin
			converter_start_o <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (convert_start_i && cfg_i.burst_mode_enable) begin
						state     <= ST_POWERUP;
						pwr_count <= '0;
						busy_o    <= 1'b1;
					end else if (convert_start_i) begin
						state             <= ST_CONVERT;
						converter_start_o <= 1'b1;
						busy_o            <= 1'b1;
					end
				end
				ST_POWERUP: begin
					// converter needs settling time before the first track
					if (pwr_count == PWR_LAST) begin
						state             <= ST_CONVERT;
						converter_start_o <= 1'b1;
					end else begin
						pwr_count <= pwr_count + 1'b1;
					end
				end
				ST_CONVERT: begin
					if (sample_valid_i) begin
						if (cfg_i.burst_mode_enable && !series_last) begin
							converter_start_o <= 1'b1;
						end else begin
							state  <= ST_IDLE;
							busy_o <= 1'b0;
						end
					end
				end
				default: begin
					state  <= ST_IDLE;
					busy_o <= 1'b0;
				end
			endcase
		end
	end

	// converter power: always on in normal mode, burst drops it after a series
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i)
			converter_enable_o <= 1'b0;
		else if (!cfg_i.burst_mode_enable)
			converter_enable_o <= 1'b1;
		else if (state == ST_IDLE && convert_start_i)
			converter_enable_o <= 1'b1;
		else if (series_last)
			converter_enable_o <= 1'b0;
	end

	AST_RESULT_ONLY_AT_END: assert property (
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		!$stable(result_o) |-> $past(series_last)
	) else $error("result bytes changed outside series end");

	AST_FLAG_RISE_CAUSE: assert property (
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		$rose(conversion_done_flag_o) |-> $past(series_last)
	) else $error("done flag rose without a finished series");

	AST_FLAG_SET_WINS: assert property (
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		series_last |=> conversion_done_flag_o && result_o == $past(formatted)
	) else $error("series end did not set flag with its result");

	AST_RIGHT_UNUSED_ZERO: assert property (
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		series_last && cfg_i.repeat_count_select == RPT_1
		&& cfg_i.justify_shift_select == JUST_RIGHT
		|=> result_o.result_high_byte[7:2] == 6'h00
	) else $error("unused high bits not zero in right justified result");

	AST_LEFT_JUSTIFY: assert property (
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		series_last && cfg_i.justify_shift_select == JUST_LEFT
		&& cfg_i.repeat_count_select == RPT_1
		|=> result_o == {$past(sample_data_i), 6'h00}
	) else $error("left justified result misplaced");

	AST_SHIFT_ONE: assert property (
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		series_last && cfg_i.justify_shift_select == JUST_SHR1
		|=> result_o == ($past(next_total) >> 1)
	) else $error("shift right by one wrong");

	AST_SERIES_RESTART: assert property (
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		sample_valid_i && sample_count == 7'h00
		|=> acc == {6'h00, $past(sample_data_i)}
	) else $error("accumulator not restarted at series start");

	AST_COUNT_BOUND: assert property (
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		sample_count < series_len || !$stable(cfg_i)
	) else $error("sample count ran past repeat count");

	AST_BURST_SHUTDOWN: assert property (
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		series_last && cfg_i.burst_mode_enable && $stable(cfg_i)
		|=> !converter_enable_o && !busy_o
	) else $error("burst did not power converter down");

	AST_BURST_FIRST_START: assert property (
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		state == ST_IDLE && convert_start_i && cfg_i.burst_mode_enable
		|=> converter_enable_o ##[1:PWR_BOUND] converter_start_o
	) else $error("burst start did not launch a conversion");

endmodule

//--- tb_adc_result_accumulator.sv
`timescale 1ns/1ns
module tb_adc_result_accumulator;
	import adc_acc_pkg::*;

	// short power-up wait keeps burst series quick
	localparam int PW = 4;

	logic                sys_clk_i;
	logic                sys_rst_i;
	acc_cfg_t            cfg_i;
	logic                convert_start_i;
	logic                done_clear_i;
	logic                sample_valid_i;
	logic [SAMPLE_W-1:0] sample_data_i;
	result_t             result_o;
	logic                done_flag;
	logic                busy;
	logic                conv_en;
	logic                conv_st;
	int                  error_cnt;
	int                  num_checks;
	int                  cyc;
	logic [31:0]         rng;

	adc_result_accumulator #(.PWRUP_WAIT(PW)) dut_u (
		.sys_clk_i              (sys_clk_i),
		.sys_rst_i              (sys_rst_i),
		.cfg_i                  (cfg_i),
		.convert_start_i        (convert_start_i),
		.done_clear_i           (done_clear_i),
		.sample_valid_i         (sample_valid_i),
		.sample_data_i          (sample_data_i),
		.result_o               (result_o),
		.conversion_done_flag_o (done_flag),
		.busy_o                 (busy),
		.converter_enable_o     (conv_en),
		.converter_start_o      (conv_st)
	);

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// xorshift so every run sees the same samples
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	function automatic int lenf(input logic [2:0] r);
		return (r == 3'h0) ? 1 : (r > 3'h4) ? 64 : (2 << r);
	endfunction

	// left justify only meaningful for single samples
	function automatic logic [15:0] fmt(input logic [15:0] s, input logic [2:0] j);
		case (j)
			3'h0:    return s;
			3'h1:    return s >> 1;
			3'h2:    return s >> 2;
			3'h3:    return s >> 3;
			default: return {s[9:0], 6'h00};
		endcase
	endfunction

	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// one whole series; normal mode needs a start per sample
	task automatic series(input logic b, input logic [2:0] r, input logic [2:0] j,
			input bit rnd, input logic [9:0] v);
		int n;
		int k;
		logic [15:0] sum;
		logic [15:0] prev;
		logic [9:0] d;
		n = lenf(r);
		sum = 16'h0000;
		prev = result_o;
		@(posedge sys_clk_i);
		cfg_i.burst_mode_enable <= b;
		cfg_i.repeat_count_select <= r;
		cfg_i.justify_shift_select <= j;
		done_clear_i <= 1'b1;
		@(posedge sys_clk_i);
		done_clear_i <= 1'b0;
		@(negedge sys_clk_i);
		chk("flag cleared", done_flag, 16'h0000);
		for (int i = 0; i < n; i++) begin
			d = rnd ? 10'(xs()) : v;
			sum = sum + d;
			if (!b || i == 0) begin
				k = 0;
				do @(negedge sys_clk_i); while (busy !== 1'b0 && ++k < 400);
				@(posedge sys_clk_i);
				convert_start_i <= 1'b1;
				@(posedge sys_clk_i);
				convert_start_i <= 1'b0;
				@(negedge sys_clk_i);
				chk("busy after start", busy, 16'h0001);
				if (b) begin
					chk("burst enable", conv_en, 16'h0001);
				end
			end
			// look at this negedge first: a burst restart pulse stands one cycle only
			k = 0;
			while (conv_st !== 1'b1 && k < 400) begin
				@(negedge sys_clk_i);
				k++;
			end
			chk("converter start", conv_st, 16'h0001);
			@(posedge sys_clk_i);
			sample_valid_i <= 1'b1;
			sample_data_i <= d;
			@(posedge sys_clk_i);
			sample_valid_i <= 1'b0;
			if (i < n - 1) begin
				@(negedge sys_clk_i);
				chk("flag mid series", done_flag, 16'h0000);
				chk("result mid series", result_o, prev);
			end
		end
		k = 0;
		do @(negedge sys_clk_i); while (done_flag !== 1'b1 && ++k < 8);
		chk("flag at end", done_flag, 16'h0001);
		chk("busy at end", busy, 16'h0000);
		chk("result", result_o, fmt(sum, j));
		if (b) begin
			chk("burst shutdown", conv_en, 16'h0000);
		end
		$display("test done burst %0d repeat %0d justify %0d", b, r, j);
	endtask

	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt++;
			summarize();
		end
	end

	initial begin
		sys_rst_i = 1'b1;
		cfg_i = '0;
		convert_start_i = 1'b0;
		done_clear_i = 1'b0;
		sample_valid_i = 1'b0;
		sample_data_i = 10'h000;
		error_cnt = 0;
		num_checks = 0;
		cyc = 0;
		rng = 32'h0000005e;
		repeat (5) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		@(negedge sys_clk_i);
		chk("result after reset", result_o, RESULT_RST);
		// full scale and mid scale corners, then every repeat code both modes
		series(1'b0, RPT_1, JUST_RIGHT, 1'b0, 10'h3ff);
		series(1'b0, RPT_1, JUST_LEFT, 1'b0, 10'h3ff);
		series(1'b1, RPT_1, JUST_LEFT, 1'b0, 10'h200);
		series(1'b1, 3'h7, JUST_RIGHT, 1'b0, 10'h3ff);
		series(1'b0, RPT_4, JUST_SHR1, 1'b0, 10'h3ff);
		for (int t = 0; t < 16; t++) begin
			series(t[3], t[2:0], (t[2:0] == 3'h0) ? 3'(xs() % 8) : 3'(xs() % 4), 1'b1, 10'h000);
		end
		summarize();
	end
endmodule
